// ### verif/acof_capture_model.sv
`timescale 1ns/1ns
module acof_capture_model (
    input  wire        clk_sys_in,
    input  wire        rstn_in,
    input  wire [7:0]  output_bus_in,
    input  wire        output_valid_in,
    input  wire        output_first_in,
    input  wire [1:0]  format_in,
    input  wire        slow_in,
    output reg         output_ready_out,
    output reg  [15:0] word_out,
    output reg         word_strobe_out
);
    reg [15:0] acc = 16'h0;
    int        cnt = 0;
    always @(posedge clk_sys_in) begin
        word_strobe_out <= 1'b0;
        // stalls at random, slow mode takes about half
        output_ready_out <= rstn_in && ($urandom % 4 > (slow_in ? 1 : 0));
        if (output_valid_in && output_ready_out) begin
            if (format_in == 2'h3)
                acc = (output_first_in ? 16'h0 : acc << 4)
                      | output_bus_in[7:4];
            else
                acc = (output_first_in ? 16'h0 : acc << 8) | output_bus_in;
            cnt = output_first_in ? 1 : cnt + 1;
            if (cnt == (format_in == 2'h3 ? 4 : 2)) begin
                word_out <= acc;
                word_strobe_out <= 1'b1;
            end
        end
    end
endmodule // acof_capture_model

// ### verif/acof_tb_top.sv
`timescale 1ns/1ns
module acof_tb_top;
    reg               clk_sys_in = 1'b0;
    reg               rstn_in = 1'b0;
    reg               pixel_sync_in = 1'b0;
    reg               clamp_or_cycle_pin_in = 1'b0;
    reg signed [15:0] video_level_in = 16'sh0;
    reg signed [15:0] reset_level_in = 16'sh0;
    reg signed [15:0] reference_level_pin_in = 16'sh0;
    reg [4:0]         s_axi_awaddr = 5'h0;
    reg [4:0]         s_axi_araddr = 5'h0;
    reg [31:0]        s_axi_wdata = 32'h0;
    reg [3:0]         s_axi_wstrb = 4'h0;
    reg               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    reg               s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    reg               s_axi_rready = 1'b0, slow = 1'b0;
    reg [1:0]         fmt = 2'h0;
    wire              output_ready_in, output_valid_out, output_first_out;
    wire              clamp_pulse_out, clamp_level_range_out, cap_strobe;
    wire              clamp_level_dac_en_out, s_axi_awready, s_axi_wready;
    wire              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [7:0]        output_bus_out;
    wire [3:0]        clamp_level_code_out;
    wire [1:0]        input_select_out, s_axi_bresp, s_axi_rresp;
    wire [31:0]       s_axi_rdata;
    wire [15:0]       cap_word;
    int error_cnt = 0, checks_done = 0, clamp_seen = 0, clamp_exp = 0;
    int ds, rng, inv, ace, ics, csi, ofs, gn, rs, colour, ctrl, f, ew;
    int exp_q[$];
    reg [31:0] d;
    reg [1:0]  r;

    always #10 clk_sys_in = ~clk_sys_in;

    acof_top i_acof_top (.*);
    acof_capture_model i_acof_capture_model (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .output_bus_in(output_bus_out), .output_valid_in(output_valid_out),
        .output_first_in(output_first_out), .format_in(fmt), .slow_in(slow),
        .output_ready_out(output_ready_in), .word_out(cap_word),
        .word_strobe_out(cap_strobe));

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input [4:0] a, input [31:0] v, input [3:0] s, output [1:0] q);
        @(posedge clk_sys_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [4:0] a, output [31:0] v, output [1:0] q);
        @(posedge clk_sys_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        q = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task pix;
        int v, rf, p, c, w;
        v = $urandom % 16000 - 8000;
        rf = $urandom % 16000 - 8000;
        p = $urandom % 2;
        c = ace ? colour : (ics == 3 ? 0 : ics);
        w = (ds ? v - rs : v - rf) + 16 * (((ofs >> 8 * c) & 255) - 128);
        w = (w * ((gn >> 8 * c) & 255)) >>> 5;
        w += rng == 3 ? 0 : rng == 2 ? 65535 : 32767;
        w = w < 0 ? 0 : w > 65535 ? 65535 : w;
        exp_q.push_back(inv ? 65535 - w : w);
        clamp_exp += ace ? csi : p;
        @(posedge clk_sys_in);
        pixel_sync_in <= 1'b1;
        clamp_or_cycle_pin_in <= ace ? 1'b0 : p[0];
        video_level_in <= v[15:0];
        reference_level_pin_in <= rf[15:0];
        @(posedge clk_sys_in);
        pixel_sync_in <= 1'b0;
        clamp_or_cycle_pin_in <= 1'b0;
        repeat (12) @(posedge clk_sys_in);
        if (ace && p) begin
            clamp_or_cycle_pin_in <= 1'b1;
            @(posedge clk_sys_in);
            clamp_or_cycle_pin_in <= 1'b0;
            colour = (colour + 1) % 3;
            repeat (3) @(posedge clk_sys_in);
            chk("colour", colour, input_select_out);
        end
        repeat (12) @(posedge clk_sys_in);
    endtask

    always @(posedge clk_sys_in) begin
        if (cap_strobe === 1'b1)
            ew = exp_q.size() ? exp_q.pop_front() : -1;
        if (cap_strobe === 1'b1 && ew < 0)
            chk("extra word", 0, 1);
        else if (cap_strobe === 1'b1)
            chk("word", ew, cap_word);
        if (clamp_pulse_out === 1'b1)
            clamp_seen++;
    end

    initial begin
        repeat (30000) @(posedge clk_sys_in);
        error_cnt++;
        final_report;
    end

    initial begin
        void'($urandom(52));
        rs = $urandom % 16000 - 8000;
        reset_level_in <= rs[15:0];
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        wr(5'h18, 32'hffffffff, 4'hf, r);
        chk("bad write resp", 2, r);
        rd(5'h00, d, r);
        chk("ctrl reset", 1, d);
        rd(5'h14, d, r);
        chk("bad read resp", 2, r);
        chk("bad read data", 0, d);
        wr(5'h04, 32'h11223344, 4'h1, r);
        rd(5'h04, d, r);
        chk("offset lane", 32'h808044, d);
        rd(5'h08, d, r);
        chk("gain reset", 32'h808080, d);
        // ranges and inversion paired, then auto-cycle runs
        for (int i = 0; i < 12; i++) begin
            ds = i == 0 ? 0 : $urandom % 2;
            rng = i % 4;
            inv = (i / 4) % 2;
            ace = i >= 8;
            ics = $urandom % 4;
            csi = $urandom % 2;
            f = (i + i / 4) % 4;
            ofs = $urandom % 32'h1000000;
            gn = $urandom % 32'h1000000;
            ctrl = ds | ($urandom % 4) << 1 | rng << 3 | inv << 5 | f << 6
                   | ($urandom % 4) << 8 | ace << 10 | ics << 12 | csi << 14
                   | ($urandom % 64) << 15;
            wr(5'h00, ctrl, 4'hf, r);
            wr(5'h04, ofs, 4'hf, r);
            wr(5'h08, gn, 4'hf, r);
            wr(5'h10, 32'h0, 4'hf, r);
            colour = 0;
            fmt <= f[1:0];
            slow <= i % 2;
            rd(5'h00, d, r);
            chk("ctrl", ctrl, d);
            chk("level code", ctrl[18:15], clamp_level_code_out);
            chk("level range", ctrl[19], clamp_level_range_out);
            chk("dac enable", !ctrl[20], clamp_level_dac_en_out);
            repeat (6) pix;
            repeat (40) @(posedge clk_sys_in);
            chk("clamp count", clamp_exp, clamp_seen);
            chk("words left", 0, exp_q.size());
        end
        rd(5'h0c, d, r);
        chk("overrun", 0, d[3]);
        final_report;
    end
endmodule // acof_tb_top

// ### verif/acof_top_asserts.sv
`timescale 1ns/1ns
module acof_top_asserts (
    input wire        clk_sys_in,
    input wire        rstn_in,
    input wire        pixel_sync_in,
    input wire        output_ready_in,
    input wire [7:0]  output_bus_out,
    input wire        output_valid_out,
    input wire        output_first_out,
    input wire        clamp_pulse_out,
    input wire        clamp_level_dac_en_out,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    property p_clamp_one;
        clamp_pulse_out |=> !clamp_pulse_out;
    endproperty
    a_clamp_one: assert property (p_clamp_one)
        else $error("clamp pulse too long");
    // window covers every reset sample position
    property p_clamp_sync;
        clamp_pulse_out |-> $past(pixel_sync_in, 2) || $past(pixel_sync_in, 3)
            || $past(pixel_sync_in, 4) || $past(pixel_sync_in, 5)
            || $past(pixel_sync_in, 6) || $past(pixel_sync_in, 7);
    endproperty
    a_clamp_sync: assert property (p_clamp_sync)
        else $error("clamp pulse without pixel sync");
    property p_part_hold;
        output_valid_out && !output_ready_in |=> output_valid_out
            && $stable(output_bus_out) && $stable(output_first_out);
    endproperty
    a_part_hold: assert property (p_part_hold)
        else $error("output part dropped while stalled");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    property p_r_cause;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_r_cause: assert property (p_r_cause)
        else $error("read answer without request");
    property p_b_cause;
        $rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready, 2)
            || $past(s_axi_awvalid && s_axi_awready, 2);
    endproperty
    a_b_cause: assert property (p_b_cause)
        else $error("write answer without request");
    property p_rst_state;
        disable iff (1'b0) !rstn_in |=> !output_valid_out && !clamp_pulse_out
            && clamp_level_dac_en_out && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("outputs wrong in reset");
endmodule // acof_top_asserts

bind acof_top acof_top_asserts i_acof_top_asserts (
    .clk_sys_in, .rstn_in, .pixel_sync_in, .output_ready_in, .output_bus_out,
    .output_valid_out, .output_first_out, .clamp_pulse_out,
    .clamp_level_dac_en_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// ### verilog/acof_defs.vh
`ifndef ACOF_DEFS_VH
`define ACOF_DEFS_VH
// register byte offsets
`define ACOF_CTRL_ADDR      4'h0
`define ACOF_OFFSET_ADDR    4'h4
`define ACOF_GAIN_ADDR      4'h8
`define ACOF_STATUS_ADDR    4'hc
`define ACOF_CYCRST_ADDR    4'h0
`define ACOF_CYCRST_ADDR_B  4'h0
`define ACOF_CYCLE_ADDR     5'h10
// control field positions
`define ACOF_CDS_BIT        0
`define ACOF_RSP_LSB        1
`define ACOF_ARP_LSB        3
`define ACOF_INV_BIT        5
`define ACOF_FMT_LSB        6
`define ACOF_LAT_LSB        8
`define ACOF_ACE_BIT        10
`define ACOF_FME_BIT        11
`define ACOF_ICS_LSB        12
`define ACOF_CSI_BIT        14
`define ACOF_CLC_LSB        15
`define ACOF_CLR_BIT        19
`define ACOF_CLE_BIT        20
// reset values
`define ACOF_CTRL_RESET     21'h000001
`define ACOF_COEF_RESET     24'h808080
// converter offsets and limits
`define ACOF_MID_OFFSET     27'sh0007fff
`define ACOF_TOP_OFFSET     27'sh000ffff
`define ACOF_WORD_MAX       16'hffff
`define ACOF_PHASE_MAX      3'h7
// bus answers
`define ACOF_RESP_OKAY      2'h0
`define ACOF_RESP_SLVERR    2'h2
`endif

// ### verilog/acof_fifo2.v
`timescale 1ns/1ns
module acof_fifo2 #(
    parameter WIDTH = 16
) (
    input  wire             clk_sys_in,
    input  wire             rstn_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg             wptr_reg;
    reg             rptr_reg;
    reg [1:0]       count_reg;
    wire            push;
    wire            pop;

    assign wr_ready_out = (count_reg != 2'h2);
    assign rd_valid_out = (count_reg != 2'h0);
    assign rd_data_out  = mem_reg[rptr_reg];
    assign push = wr_valid_in & wr_ready_out;
    assign pop  = rd_valid_out & rd_ready_in;

    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            wptr_reg  <= 1'b0;
            rptr_reg  <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wptr_reg] <= wr_data_in;
                wptr_reg          <= ~wptr_reg;
            end
            if (pop)
                rptr_reg <= ~rptr_reg;
            if (push & ~pop)
                count_reg <= count_reg + 2'h1;
            else if (pop & ~push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule // acof_fifo2

// ### verilog/acof_top.v
// Contract
// - sample clamp pin during pixel sync
// - sampled high gives clamp on next reset
// - auto-cycle uses internal clamp select bit
// - clamp pulse from clock and sync
// - two-bit field positions clamp and reset sample
// - clamp level code, range, external select
// - double sampling references prior reset level
// - otherwise reference pin sampled with video
// - per-channel 8-bit offset and gain
// - auto-cycle steps red, green, blue, red
// - range position places black level
// - 16-bit word, code offsets, clipped
// - invert gives 65535 minus word
// - byte format, high byte first; format 3 sends four nibbles, high nibble first
// - two-bit programmable output latency
// - pin is cycle input only when enabled
`timescale 1ns/1ns
`include "acof_defs.vh"
module acof_top (
    input  wire               clk_sys_in,
    input  wire               rstn_in,
    input  wire               pixel_sync_in,
    input  wire               clamp_or_cycle_pin_in,
    input  wire signed [15:0] video_level_in,
    input  wire signed [15:0] reset_level_in,
    input  wire signed [15:0] reference_level_pin_in,
    input  wire               output_ready_in,
    output reg  [7:0]         output_bus_out,
    output reg                output_valid_out,
    output reg                output_first_out,
    output reg                clamp_pulse_out,
    output reg  [3:0]         clamp_level_code_out,
    output reg                clamp_level_range_out,
    output reg                clamp_level_dac_en_out,
    output reg  [1:0]         input_select_out,
    input  wire [4:0]         s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output reg                s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output reg                s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [4:0]         s_axi_araddr,
    input  wire               s_axi_arvalid,
    output reg                s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready
);
    reg  [20:0]        ctrl_reg;
    reg  [23:0]        offset_reg;
    reg  [23:0]        gain_reg;
    reg                aw_got_reg;
    reg                w_got_reg;
    reg  [4:0]         aw_addr_reg;
    reg  [31:0]        w_data_reg;
    reg  [3:0]         w_strb_reg;
    reg                cycle_reset_reg;
    reg                sync_prev_reg;
    reg                pin_prev_reg;
    reg                clamp_req_reg;
    reg  [2:0]         phase_reg;
    reg signed [15:0]  reset_hold_reg;
    reg  [1:0]         colour_reg;
    reg signed [16:0]  v1_reg;
    reg  [1:0]         v1_colour_reg;
    reg                v1_valid_reg;
    reg  [15:0]        word_reg;
    reg                word_valid_reg;
    reg                overrun_reg;
    reg  [15:0]        shift_reg;
    reg  [1:0]         parts_reg;
    reg  [1:0]         wait_reg;
    reg                busy_reg;
    reg  [15:0]        last_word_reg;
    reg  [31:0]        rdata_next;
    reg  [23:0]        wmerge_next;
    reg signed [26:0]  conv_next;
    reg  [15:0]        word_next;
    wire               fifo_wr_ready;
    wire [15:0]        fifo_rd_data;
    wire               fifo_rd_valid;
    wire               ser_take;
    wire               sample_now;
    wire               auto_cycle;
    wire [1:0]         coef_colour;
    wire [2:0]         clamp_phase;
    wire [7:0]         off_sel;
    wire [7:0]         gain_sel;
    wire [1:0]         arp;
    wire [1:0]         fmt;
    wire signed [16:0] v2;
    wire signed [26:0] v3;
    wire               wr_fire;

    assign arp = ctrl_reg[`ACOF_ARP_LSB+1:`ACOF_ARP_LSB];
    assign fmt = ctrl_reg[`ACOF_FMT_LSB+1:`ACOF_FMT_LSB];
    assign auto_cycle = ctrl_reg[`ACOF_ACE_BIT];
    assign sample_now = sync_prev_reg & ~pixel_sync_in;
    assign clamp_phase = {1'b0, ctrl_reg[`ACOF_RSP_LSB+1:`ACOF_RSP_LSB]}
                       + 3'h1;
    assign coef_colour = auto_cycle ? colour_reg
                       : ctrl_reg[`ACOF_ICS_LSB+1:`ACOF_ICS_LSB];
    assign off_sel  = (v1_colour_reg == 2'h1) ? offset_reg[15:8]
                    : (v1_colour_reg == 2'h2) ? offset_reg[23:16]
                    : offset_reg[7:0];
    assign gain_sel = (v1_colour_reg == 2'h1) ? gain_reg[15:8]
                    : (v1_colour_reg == 2'h2) ? gain_reg[23:16]
                    : gain_reg[7:0];
    // offset code 128 is zero correction
    assign v2 = v1_reg + $signed({1'b0, off_sel, 4'h0})
              - $signed({5'h0, 8'h80, 4'h0});
    assign v3 = (v2 * $signed({2'b00, gain_sel})) >>> 5;
    assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    assign ser_take = fifo_rd_valid & ~busy_reg;

    acof_fifo2 #(
        .WIDTH (16)
    ) u_fifo (
        .clk_sys_in   (clk_sys_in),
        .rstn_in      (rstn_in),
        .wr_data_in   (word_reg),
        .wr_valid_in  (word_valid_reg),
        .wr_ready_out (fifo_wr_ready),
        .rd_data_out  (fifo_rd_data),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (~busy_reg)
    );

    always @* begin
        case (arp)
            2'h2:    conv_next = v3 + `ACOF_TOP_OFFSET;
            2'h3:    conv_next = v3;
            default: conv_next = v3 + `ACOF_MID_OFFSET;
        endcase
        if (conv_next < 27'sh0)
            word_next = 16'h0000;
        else if (conv_next > `ACOF_TOP_OFFSET)
            word_next = `ACOF_WORD_MAX;
        else
            word_next = conv_next[15:0];
        if (ctrl_reg[`ACOF_INV_BIT])
            word_next = `ACOF_WORD_MAX - word_next;
    end

    always @* begin
        case (aw_addr_reg[3:0])
            `ACOF_OFFSET_ADDR: wmerge_next = offset_reg;
            default:           wmerge_next = gain_reg;
        endcase
        if (w_strb_reg[0])
            wmerge_next[7:0] = w_data_reg[7:0];
        if (w_strb_reg[1])
            wmerge_next[15:8] = w_data_reg[15:8];
        if (w_strb_reg[2])
            wmerge_next[23:16] = w_data_reg[23:16];
    end

    always @* begin
        case (s_axi_araddr)
            {1'b0, `ACOF_CTRL_ADDR}:   rdata_next = {11'h0, ctrl_reg};
            {1'b0, `ACOF_OFFSET_ADDR}: rdata_next = {8'h0, offset_reg};
            {1'b0, `ACOF_GAIN_ADDR}:   rdata_next = {8'h0, gain_reg};
            {1'b0, `ACOF_STATUS_ADDR}:
                rdata_next = {last_word_reg, 12'h0, overrun_reg,
                              clamp_req_reg, colour_reg};
            default:                   rdata_next = 32'h0;
        endcase
    end

    // register bus slave
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ctrl_reg        <= `ACOF_CTRL_RESET;
            offset_reg      <= `ACOF_COEF_RESET;
            gain_reg        <= `ACOF_COEF_RESET;
            aw_got_reg      <= 1'b0;
            w_got_reg       <= 1'b0;
            aw_addr_reg     <= 5'h0;
            w_data_reg      <= 32'h0;
            w_strb_reg      <= 4'h0;
            cycle_reset_reg <= 1'b0;
            s_axi_awready   <= 1'b0;
            s_axi_wready    <= 1'b0;
            s_axi_bvalid    <= 1'b0;
            s_axi_bresp     <= `ACOF_RESP_OKAY;
            s_axi_arready   <= 1'b0;
            s_axi_rvalid    <= 1'b0;
            s_axi_rresp     <= `ACOF_RESP_OKAY;
            s_axi_rdata     <= 32'h0;
        end else begin
            cycle_reset_reg <= 1'b0;
            s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `ACOF_RESP_OKAY;
                case (aw_addr_reg)
                    {1'b0, `ACOF_CTRL_ADDR}: begin
                        if (w_strb_reg[0])
                            ctrl_reg[7:0] <= w_data_reg[7:0];
                        if (w_strb_reg[1])
                            ctrl_reg[15:8] <= w_data_reg[15:8];
                        if (w_strb_reg[2])
                            ctrl_reg[20:16] <= w_data_reg[20:16];
                    end
                    {1'b0, `ACOF_OFFSET_ADDR}: offset_reg <= wmerge_next;
                    {1'b0, `ACOF_GAIN_ADDR}:   gain_reg <= wmerge_next;
                    `ACOF_CYCLE_ADDR:          cycle_reset_reg <= 1'b1;
                    {1'b0, `ACOF_STATUS_ADDR}: ;
                    default: s_axi_bresp <= `ACOF_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdata_next;
                s_axi_rresp  <= (s_axi_araddr[4] | (s_axi_araddr[1:0] != 2'h0))
                              ? `ACOF_RESP_SLVERR : `ACOF_RESP_OKAY;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // pixel timing, clamp and sampling
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            sync_prev_reg  <= 1'b0;
            pin_prev_reg   <= 1'b0;
            clamp_req_reg  <= 1'b0;
            phase_reg      <= `ACOF_PHASE_MAX;
            reset_hold_reg <= 16'sh0;
            colour_reg     <= 2'h0;
            v1_reg         <= 17'sh0;
            v1_colour_reg  <= 2'h0;
            v1_valid_reg   <= 1'b0;
            clamp_pulse_out        <= 1'b0;
            clamp_level_code_out   <= 4'h0;
            clamp_level_range_out  <= 1'b0;
            clamp_level_dac_en_out <= 1'b1;
            input_select_out       <= 2'h0;
        end else begin
            sync_prev_reg <= pixel_sync_in;
            pin_prev_reg  <= clamp_or_cycle_pin_in;
            if (pixel_sync_in)
                clamp_req_reg <= auto_cycle ? ctrl_reg[`ACOF_CSI_BIT]
                                            : clamp_or_cycle_pin_in;
            if (sample_now)
                phase_reg <= 3'h1;
            else if (phase_reg != `ACOF_PHASE_MAX)
                phase_reg <= phase_reg + 3'h1;
            clamp_pulse_out <= clamp_req_reg & (phase_reg == clamp_phase)
                             & ~sample_now;
            // reset level taken at chosen phase
            if (phase_reg == clamp_phase && !sample_now)
                reset_hold_reg <= reset_level_in;
            if (cycle_reset_reg)
                colour_reg <= 2'h0;
            else if (auto_cycle & clamp_or_cycle_pin_in & ~pin_prev_reg)
                colour_reg <= (colour_reg == 2'h2) ? 2'h0
                                                   : colour_reg + 2'h1;
            input_select_out <= ctrl_reg[`ACOF_FME_BIT]
                ? ctrl_reg[`ACOF_ICS_LSB+1:`ACOF_ICS_LSB] : coef_colour;
            clamp_level_code_out   <= ctrl_reg[`ACOF_CLC_LSB+3:`ACOF_CLC_LSB];
            clamp_level_range_out  <= ctrl_reg[`ACOF_CLR_BIT];
            clamp_level_dac_en_out <= ~ctrl_reg[`ACOF_CLE_BIT];
            v1_valid_reg <= sample_now;
            if (sample_now) begin
                v1_colour_reg <= coef_colour;
                if (ctrl_reg[`ACOF_CDS_BIT])
                    v1_reg <= video_level_in - reset_hold_reg;
                else
                    v1_reg <= video_level_in - reference_level_pin_in;
            end
        end
    end

    // word stage, buffer and output serialiser
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            word_reg         <= 16'h0;
            word_valid_reg   <= 1'b0;
            overrun_reg      <= 1'b0;
            last_word_reg    <= 16'h0;
            shift_reg        <= 16'h0;
            parts_reg        <= 2'h0;
            wait_reg         <= 2'h0;
            busy_reg         <= 1'b0;
            output_bus_out   <= 8'h00;
            output_valid_out <= 1'b0;
            output_first_out <= 1'b0;
        end else begin
            if (word_valid_reg & fifo_wr_ready)
                word_valid_reg <= 1'b0;
            if (v1_valid_reg) begin
                // stalled word is kept, newer pixel lost
                if (word_valid_reg & ~fifo_wr_ready) begin
                    overrun_reg <= 1'b1;
                end else begin
                    word_reg       <= word_next;
                    word_valid_reg <= 1'b1;
                    last_word_reg  <= word_next;
                end
            end
            if (output_valid_out & output_ready_in)
                output_valid_out <= 1'b0;
            if (ser_take) begin
                busy_reg  <= 1'b1;
                shift_reg <= fifo_rd_data;
                wait_reg  <= ctrl_reg[`ACOF_LAT_LSB+1:`ACOF_LAT_LSB];
                parts_reg <= (fmt == 2'h3) ? 2'h3 : 2'h1;
            end else if (busy_reg && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else if (busy_reg &&
                         (~output_valid_out | output_ready_in)) begin
                output_valid_out <= 1'b1;
                output_first_out <= (fmt == 2'h3) ? (parts_reg == 2'h3)
                                                  : (parts_reg == 2'h1);
                if (fmt == 2'h3) begin
                    output_bus_out <= {shift_reg[15:12], 4'h0};
                    shift_reg      <= {shift_reg[11:0], 4'h0};
                end else begin
                    output_bus_out <= shift_reg[15:8];
                    shift_reg      <= {shift_reg[7:0], 8'h00};
                end
                if (parts_reg == 2'h0)
                    busy_reg <= 1'b0;
                else
                    parts_reg <= parts_reg - 2'h1;
            end
        end
    end
endmodule // acof_top
